// ==== adsr_pkg.sv ====
// Constants, register map and carrier types of the converter status and result logic.
package adsr_pkg;
    // ------------------------------------------------------------------
    // Register map (word index on the register port).
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 16;
    localparam logic [3:0]  ADDR_CTL2     = 4'h0;
    localparam logic [3:0]  ADDR_CTL3     = 4'h1;
    localparam logic [3:0]  ADDR_CTL5     = 4'h2;
    localparam logic [3:0]  ADDR_STAT     = 4'h3;
    localparam logic [3:0]  ADDR_TEST     = 4'h4;
    localparam logic [3:0]  ADDR_PORT     = 4'h5;
    localparam logic [3:0]  ADDR_RES_BASE = 4'h8;
    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int          CTL2_PWR      = 7;
    localparam int          CTL2_FFC      = 6;
    localparam int          CTL2_HIW      = 5;
    localparam int          CTL5_S8       = 6;
    localparam int          CTL5_SCAN     = 5;
    localparam int          CTL5_MULT     = 4;
    localparam int          STAT_SCF      = 15;
    localparam int          STAT_PTR_LO   = 8;
    localparam int          TEST_SAR_LO   = 6;
    localparam int          TEST_RST      = 5;
    localparam int          TEST_OUT      = 4;
    localparam int          RES_LO        = 6;
    localparam int          SAR_W         = 10;
    localparam int          NRES          = 8;
    localparam logic [2:0]  LAST_OF_4     = 3'h3;
    localparam logic [2:0]  LAST_OF_8     = 3'h7;
    localparam logic [3:0]  GRP_MASK_4    = 4'hC;
    localparam logic [3:0]  GRP_MASK_8    = 4'h8;
    localparam logic [1:0]  FRZ_CONT      = 2'h0;
    // ------------------------------------------------------------------
    // Timing: stop recovery time and its cycle count at 100 MHz.
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          T_SR_NS       = 500;
    localparam int          T_SR_CYC      = (T_SR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RECOV_W       = 8;
    // ------------------------------------------------------------------
    // Carrier types towards the converter core.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             run;       // Core may convert.
        logic [3:0]       channel;   // Channel being converted.
        logic             sar_load;  // One-cycle load of the approximation value.
        logic [SAR_W-1:0] sar_data;  // Value to load.
    } adsr_core_req_t;
    typedef struct packed {
        logic             done;      // One-cycle end of a conversion.
        logic [SAR_W-1:0] data;      // Conversion result.
        logic [SAR_W-1:0] sar;       // Live approximation value.
    } adsr_core_rsp_t;
endpackage

// ==== adsr_status.sv ====
// Status flags, conversion pointer, results, test register and mode control of the converter.
module adsr_status
    import adsr_pkg::*;
(
    input  wire logic                   clk_i,          // 100 MHz clock.
    input  wire logic                   rst_n_i,        // Asynchronous reset, active low.
    input  wire logic [adsr_pkg::ADDR_W-1:0] addr_i,    // Register index.
    input  wire logic [adsr_pkg::DATA_W-1:0] wdata_i,   // Write data.
    input  wire logic                   wr_i,           // Write strobe.
    input  wire logic                   rd_i,           // Read strobe.
    output logic [adsr_pkg::DATA_W-1:0] rdata_o,        // Read data, cycle after strobe.
    input  wire logic                   special_mode_i, // Special operating mode.
    input  wire logic                   stop_mode_i,    // Stop mode.
    input  wire logic                   wait_mode_i,    // Wait mode.
    input  wire logic                   debug_mode_i,   // Background debug active.
    input  wire logic [7:0]             pad_i,          // Analog-capable pins.
    input  wire adsr_pkg::adsr_core_rsp_t core_rsp_i,   // From converter core.
    output adsr_pkg::adsr_core_req_t    core_req_o,     // To converter core.
    output logic [3:0]                  test_sel_o,     // Factory test select.
    output logic                        test_out_en_o   // Test signal to output mux.
);
    import adsr_pkg::*;

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    logic             pwr_ff, ffc_ff, hiw_ff;
    logic [1:0]       frz_ff;
    logic             s8_ff, scan_ff, mult_ff;
    logic [3:0]       chan_ff;
    logic             scf_ff, active_ff, pend_ff, first_ff;
    logic [2:0]       ptr_ff;
    logic [NRES-1:0]  ccf_ff, armed_ff;
    logic [RECOV_W-1:0] recov_ff;
    logic             stop_d_ff;
    logic [7:0]       pad_s1_ff, pad_s2_ff;
    logic [DATA_W-1:0] res_mem [NRES];
    logic [DATA_W-1:0] nxt_rdata;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    // ------------------------------------------------------------------
    // Decoding of accesses and conversion events.
    // ------------------------------------------------------------------
    logic            wr_ctl5, rd_stat, rd_res, soft_rst, halt, conv_ok, last, launch;
    logic            set_scf;
    logic [2:0]      rd_idx, last_idx;
    logic [NRES-1:0] set_ccf, clr_ccf;

    assign wr_ctl5  = wr_i && hit(addr_i, ADDR_CTL5);
    assign rd_stat  = rd_i && hit(addr_i, ADDR_STAT);
    assign rd_res   = rd_i && addr_i[ADDR_W-1];
    assign rd_idx   = addr_i[2:0];
    assign soft_rst = wr_i && special_mode_i && hit(addr_i, ADDR_TEST)
                      && wdata_i[TEST_RST];
    // Conversion is held off by power-down, wait with halt, or debug freeze.
    assign halt     = !pwr_ff || (wait_mode_i && hiw_ff)
                      || (debug_mode_i && frz_ff != FRZ_CONT);
    assign last_idx = s8_ff ? LAST_OF_8 : LAST_OF_4;
    assign conv_ok  = core_rsp_i.done && active_ff && !halt && !stop_mode_i && !wr_ctl5;
    assign last     = (ptr_ff == last_idx);
    assign set_scf  = conv_ok && last && (!scan_ff || first_ff);
    // A start also waits out the cycle in which stop falls, before the recovery count loads.
    assign launch   = pend_ff && (recov_ff == '0) && !stop_d_ff
                      && !stop_mode_i && !wr_ctl5;
    assign set_ccf  = conv_ok ? (NRES'(1) << ptr_ff) : '0;
    // Fast clearing needs only the result read; otherwise a prior status read arms it.
    assign clr_ccf  = !rd_res ? '0 :
                      ffc_ff ? (NRES'(1) << rd_idx)
                             : (armed_ff & (NRES'(1) << rd_idx));

    // ------------------------------------------------------------------
    // Control registers; soft reset keeps the power-up bit.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_ff <= 1'b0; ffc_ff <= 1'b0; hiw_ff <= 1'b0; frz_ff <= '0;
            s8_ff <= 1'b0; scan_ff <= 1'b0; mult_ff <= 1'b0; chan_ff <= '0;
        end else if (soft_rst) begin
            ffc_ff <= 1'b0; hiw_ff <= 1'b0; frz_ff <= '0;
            s8_ff <= 1'b0; scan_ff <= 1'b0; mult_ff <= 1'b0; chan_ff <= '0;
        end else if (wr_i) begin
            if (hit(addr_i, ADDR_CTL2)) begin
                pwr_ff <= wdata_i[CTL2_PWR];
                ffc_ff <= wdata_i[CTL2_FFC];
                hiw_ff <= wdata_i[CTL2_HIW];
            end
            if (hit(addr_i, ADDR_CTL3)) begin
                frz_ff <= wdata_i[1:0];
            end
            if (wr_ctl5) begin
                s8_ff   <= wdata_i[CTL5_S8];
                scan_ff <= wdata_i[CTL5_SCAN];
                mult_ff <= wdata_i[CTL5_MULT];
                chan_ff <= wdata_i[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Stop recovery counter, loaded when stop mode ends.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_d_ff <= 1'b0;
            recov_ff  <= '0;
        end else begin
            stop_d_ff <= stop_mode_i;
            if (soft_rst) begin
                recov_ff <= '0;
            end else if (stop_d_ff && !stop_mode_i) begin
                recov_ff <= RECOV_W'(T_SR_CYC);
            end else if (recov_ff != '0) begin
                recov_ff <= recov_ff - RECOV_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer: start, pointer, abort.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_ff <= 1'b0; pend_ff <= 1'b0; first_ff <= 1'b0; ptr_ff <= '0;
        end else if (soft_rst) begin
            active_ff <= 1'b0; pend_ff <= 1'b0; first_ff <= 1'b0; ptr_ff <= '0;
        end else if (wr_ctl5) begin
            active_ff <= 1'b0;
            pend_ff   <= 1'b1;
            first_ff  <= 1'b1;
            ptr_ff    <= '0;
        end else if (stop_mode_i) begin
            active_ff <= 1'b0;
            pend_ff   <= 1'b0;
            ptr_ff    <= '0;
        end else if (launch) begin
            active_ff <= 1'b1;
            pend_ff   <= 1'b0;
            ptr_ff    <= '0;
        end else if (conv_ok) begin
            if (!last) begin
                ptr_ff <= ptr_ff + 3'h1;
            end else begin
                ptr_ff   <= '0;
                first_ff <= 1'b0;
                if (!scan_ff) begin
                    active_ff <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags: hardware set wins over every clear except soft reset and a CTL5 write.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scf_ff <= 1'b0; ccf_ff <= '0; armed_ff <= '0;
        end else if (soft_rst || wr_ctl5) begin
            scf_ff <= 1'b0; ccf_ff <= '0; armed_ff <= '0;
        end else begin
            if (set_scf) begin
                scf_ff <= 1'b1;
            end else if (wr_i && special_mode_i && hit(addr_i, ADDR_STAT)) begin
                scf_ff <= wdata_i[STAT_SCF];
            end else if (ffc_ff && rd_res && rd_idx == '0) begin
                scf_ff <= 1'b0;
            end
            if (wr_i && special_mode_i && hit(addr_i, ADDR_STAT)) begin
                ccf_ff <= wdata_i[NRES-1:0] | set_ccf;
            end else begin
                ccf_ff <= (ccf_ff & ~clr_ccf) | set_ccf;
            end
            if (rd_stat) begin
                armed_ff <= ccf_ff;
            end else begin
                armed_ff <= armed_ff & ~clr_ccf;
            end
        end
    end

    // ------------------------------------------------------------------
    // Result store: left-justified, no reset value.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (conv_ok) begin
            res_mem[ptr_ff] <= {core_rsp_i.data, {RES_LO{1'b0}}};
        end
    end

    // ------------------------------------------------------------------
    // Pin synchroniser.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_s1_ff <= '0;
            pad_s2_ff <= '0;
        end else begin
            pad_s1_ff <= pad_i;
            pad_s2_ff <= pad_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // Read multiplexer; unmapped indices read zero.
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata = '0;
        if (addr_i[ADDR_W-1]) begin
            nxt_rdata = res_mem[rd_idx];
        end else if (hit(addr_i, ADDR_CTL2)) begin
            nxt_rdata[CTL2_PWR] = pwr_ff;
            nxt_rdata[CTL2_FFC] = ffc_ff;
            nxt_rdata[CTL2_HIW] = hiw_ff;
        end else if (hit(addr_i, ADDR_CTL3)) begin
            nxt_rdata[1:0] = frz_ff;
        end else if (hit(addr_i, ADDR_CTL5)) begin
            nxt_rdata[CTL5_S8]   = s8_ff;
            nxt_rdata[CTL5_SCAN] = scan_ff;
            nxt_rdata[CTL5_MULT] = mult_ff;
            nxt_rdata[3:0]       = chan_ff;
        end else if (hit(addr_i, ADDR_STAT)) begin
            nxt_rdata[STAT_SCF]                = scf_ff;
            nxt_rdata[STAT_PTR_LO+2:STAT_PTR_LO] = ptr_ff;
            nxt_rdata[NRES-1:0]                = ccf_ff;
        end else if (hit(addr_i, ADDR_TEST) && special_mode_i) begin
            nxt_rdata[DATA_W-1:TEST_SAR_LO] = core_rsp_i.sar;
            nxt_rdata[TEST_OUT]             = test_out_en_o;
            nxt_rdata[3:0]                  = test_sel_o;
        end else if (hit(addr_i, ADDR_PORT)) begin
            nxt_rdata[7:0] = pad_s2_ff;
        end
    end

    // Registered read data, zero outside the answer cycle.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= nxt_rdata;
        end else begin
            rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Test register outputs and core request.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            test_sel_o    <= '0;
            test_out_en_o <= 1'b0;
            core_req_o    <= '0;
        end else begin
            core_req_o.sar_load <= 1'b0;
            if (soft_rst) begin
                test_sel_o    <= '0;
                test_out_en_o <= 1'b0;
            end else if (wr_i && special_mode_i && hit(addr_i, ADDR_TEST)) begin
                test_sel_o          <= wdata_i[3:0];
                test_out_en_o       <= wdata_i[TEST_OUT];
                core_req_o.sar_load <= 1'b1;
                core_req_o.sar_data <= wdata_i[DATA_W-1:TEST_SAR_LO];
            end
            core_req_o.run <= (active_ff || launch) && !halt && !stop_mode_i
                              && !wr_ctl5 && !soft_rst;
            core_req_o.channel <= mult_ff ?
                (chan_ff & (s8_ff ? GRP_MASK_8 : GRP_MASK_4)) | {1'b0, ptr_ff} : chan_ff;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence restart_s;
        wr_ctl5 && !soft_rst;
    endsequence
    sequence cleared_s;
        ptr_ff == '0 && ccf_ff == '0 && !scf_ff && !active_ff;
    endsequence
    sequence test_load_s;
        wr_i && special_mode_i && hit(addr_i, ADDR_TEST) && !wdata_i[TEST_RST];
    endsequence

    scf_single_a: assert property (conv_ok && last && !scan_ff && !soft_rst
                                   |=> scf_ff && !active_ff)
        else $error("sequence done not set at sequence end");
    scf_restart_a: assert property (restart_s |=> cleared_s)
        else $error("restart did not clear flags and pointer");
    scf_fastclr_a: assert property (ffc_ff && rd_res && rd_idx == '0 && !set_scf
                                    && !wr_i |=> !scf_ff)
        else $error("fast clear of sequence done missed");
    ptr_step_a: assert property (conv_ok && !last && !soft_rst |=> ptr_ff == $past(ptr_ff) + 3'h1)
        else $error("pointer did not advance");
    ccf_set_a: assert property (conv_ok && !soft_rst |=> ccf_ff[$past(ptr_ff)])
        else $error("completion flag not set");
    ccf_noarm_a: assert property (!ffc_ff && rd_res && !armed_ff[rd_idx] && ccf_ff[rd_idx]
                                  && !wr_i |=> ccf_ff[$past(rd_idx)])
        else $error("flag cleared without status read");
    test_zero_a: assert property (rd_i && hit(addr_i, ADDR_TEST) && !special_mode_i
                                  |=> rdata_o == '0)
        else $error("test register readable in normal mode");
    stop_abort_a: assert property (stop_mode_i |=> !active_ff ##1 !core_req_o.run)
        else $error("stop did not abort sequence");
    recov_hold_a: assert property (recov_ff != '0 |-> !launch)
        else $error("sequence launched during stop recovery");
    pwr_halt_a: assert property (!pwr_ff |=> !core_req_o.run)
        else $error("conversion ran while powered down");

    // Mode, access and test register checks.
    scf_scan_a: assert property (conv_ok && last && scan_ff && first_ff && !soft_rst
                                 |=> scf_ff)
        else $error("sequence done not set after first scan");
    ccf_fastclr_a: assert property (ffc_ff && rd_res && !set_ccf[rd_idx] && !wr_i
                                    |=> !ccf_ff[$past(rd_idx)])
        else $error("fast clear of completion flag missed");
    ccf_armclr_a: assert property (!ffc_ff && rd_res && armed_ff[rd_idx] && !set_ccf[rd_idx]
                                   && !wr_i |=> !ccf_ff[$past(rd_idx)])
        else $error("armed completion flag not cleared");
    flag_ro_a: assert property (wr_i && hit(addr_i, ADDR_STAT) && !special_mode_i && !set_scf
                                && !rd_i |=> $stable(scf_ff))
        else $error("sequence done written in normal mode");
    test_ignore_a: assert property (wr_i && hit(addr_i, ADDR_TEST) && !special_mode_i
                                    |=> $stable(test_sel_o) && !core_req_o.sar_load)
        else $error("test register written in normal mode");
    sar_load_a: assert property (test_load_s |=> core_req_o.sar_load)
        else $error("approximation value not loaded");
    soft_keep_a: assert property (soft_rst |=> $stable(pwr_ff) && !active_ff && !pend_ff
                                  && ccf_ff == '0 && !scf_ff)
        else $error("soft reset did not restore state");
    test_hold_a: assert property (!(wr_i && special_mode_i && hit(addr_i, ADDR_TEST))
                                  |=> $stable(test_sel_o) && $stable(test_out_en_o))
        else $error("test select changed without a write");
    port_read_a: assert property (rd_i && hit(addr_i, ADDR_PORT) |=> rdata_o[7:0] == $past(pad_s2_ff))
        else $error("pin levels not returned");
    recov_load_a: assert property (stop_d_ff && !stop_mode_i && !soft_rst
                                   |=> recov_ff == RECOV_W'(T_SR_CYC))
        else $error("stop recovery not started");
    wait_halt_a: assert property (wait_mode_i && hiw_ff |=> !core_req_o.run)
        else $error("conversion ran in wait with halt");
    debug_halt_a: assert property (debug_mode_i && frz_ff != FRZ_CONT |=> !core_req_o.run)
        else $error("conversion ran in debug freeze");
    seq_len_a: assert property (!s8_ff |-> ptr_ff <= LAST_OF_4)
        else $error("pointer beyond four conversions");
    scan_wrap_a: assert property (conv_ok && last && scan_ff && !soft_rst
                                  |=> ptr_ff == '0 && active_ff)
        else $error("scan did not wrap and continue");
endmodule

// ==== adsr_core_model.sv ====
// Behavioural converter core that answers the status logic with timed results.
module adsr_core_model
    import adsr_pkg::*;
#(
    parameter int LAT = 6                          // Cycles per conversion.
)(
    input  wire logic                     clk_i,   // Clock.
    input  wire logic                     rst_n_i, // Reset, active low.
    input  wire adsr_pkg::adsr_core_req_t req_i,   // Requests from the block.
    output adsr_pkg::adsr_core_rsp_t      rsp_o    // Answers to the block.
);
    timeunit 1ns;
    timeprecision 1ps;
    int                   cnt_ff;
    logic                 done_ff;
    logic [SAR_W-1:0]     sar_ff;
    // ------------------------------------------------------------------
    // Conversion timing and approximation register.
    // ------------------------------------------------------------------
    // Converts only while run is granted; a halt restarts the conversion.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff  <= 0;
            done_ff <= 1'b0;
            sar_ff  <= '0;
        end else begin
            done_ff <= req_i.run && cnt_ff == LAT - 1;
            cnt_ff  <= (req_i.run && cnt_ff < LAT - 1) ? cnt_ff + 1 : 0;
            if (req_i.sar_load) begin
                sar_ff <= req_i.sar_data;
            end
        end
    end
    // The result carries the channel so every slot can be traced.
    assign rsp_o = '{done_ff, {req_i.channel, 6'h15}, sar_ff};
endmodule

// ==== test_adsr_status.sv ====
// Self-checking bench of the converter status and result logic.
module test_adsr_status import adsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_i, rst_n_i, wr_i, rd_i, spec, stop, wt, dbg, ten;
    logic [ADDR_W-1:0]    addr_i;
    logic [DATA_W-1:0]    wdata_i, rdata_o, d;
    logic [7:0]           pad;
    logic [3:0]           tsel;
    adsr_core_req_t       req;
    adsr_core_rsp_t       rsp;
    int                   fails = 0, comparisons = 0, n;
    localparam logic [15:0] R3 = {4'h3, 6'h15, 6'h00};
    adsr_status dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .special_mode_i(spec), .stop_mode_i(stop),
        .wait_mode_i(wt), .debug_mode_i(dbg), .pad_i(pad), .core_rsp_i(rsp), .core_req_o(req),
        .test_sel_o(tsel), .test_out_en_o(ten));
    adsr_core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .rsp_o(rsp));
    // Clock at 100 MHz.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------------
    // Bus and compare tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic peek(input logic [3:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        peek(a);
        chk(d, exp);
    endtask
    // Polls status until the sequence completes, bounded.
    task automatic wait_scf;
        d = '0;
        for (int i = 0; i < 200 && d[15] !== 1'b1; i++) peek(ADDR_STAT);
    endtask
    task automatic run_is(input logic e);
        @(posedge clk_i);
        #1 chk({15'h0, req.run}, {15'h0, e});
    endtask
    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_basic;
        rd(ADDR_STAT, 16'h0000);
        rd(4'h6, 16'h0000);
        rd(ADDR_TEST, 16'h0000);
        @(posedge clk_i);
        pad <= 8'hA5;
        repeat (3) @(posedge clk_i);
        wr(ADDR_PORT, 16'h0000);
        rd(ADDR_PORT, 16'h00A5);
        $display("basic test done");
    endtask
    task automatic t_single;
        wr(ADDR_CTL2, 16'h0080);
        wr(ADDR_CTL5, 16'h0003);
        wait_scf;
        rd(ADDR_STAT, 16'h800F);
        rd(ADDR_RES_BASE + 4'h1, R3);
        rd(ADDR_STAT, 16'h800D);
        wr(ADDR_STAT, 16'h0000);
        wr(ADDR_RES_BASE + 4'h1, 16'h0000);
        rd(ADDR_STAT, 16'h800D);
        rd(ADDR_RES_BASE + 4'h1, R3);
        wr(ADDR_CTL5, 16'h0003);
        rd(ADDR_STAT, 16'h0000);
        wait_scf;
        rd(ADDR_RES_BASE + 4'h2, R3);
        @(posedge clk_i);
        spec <= 1'b1;
        wr(ADDR_STAT, 16'h8004);
        spec <= 1'b0;
        rd(ADDR_RES_BASE + 4'h2, R3);
        rd(ADDR_STAT, 16'h8004);
        rd(ADDR_RES_BASE + 4'h2, R3);
        rd(ADDR_STAT, 16'h8000);
        $display("single sequence test done");
    endtask
    task automatic t_fast;
        wr(ADDR_CTL2, 16'h00C0);
        wr(ADDR_CTL5, 16'h0053);
        wait_scf;
        rd(ADDR_STAT, 16'h80FF);
        rd(ADDR_RES_BASE + 4'h5, {4'h5, 6'h15, 6'h00});
        rd(ADDR_STAT, 16'h80DF);
        rd(ADDR_RES_BASE, {4'h0, 6'h15, 6'h00});
        rd(ADDR_STAT, 16'h00DE);
        $display("fast clear test done");
    endtask
    task automatic t_modes;
        wr(ADDR_CTL2, 16'h0080);
        wr(ADDR_CTL5, 16'h0020);
        wait_scf;
        run_is(1'b1);
        rd(ADDR_RES_BASE, {4'h0, 6'h15, 6'h00});
        @(posedge clk_i);
        wt <= 1'b1;
        run_is(1'b1);
        wr(ADDR_CTL2, 16'h00A0);
        run_is(1'b0);
        wr(ADDR_CTL2, 16'h0080);
        wt <= 1'b0;
        dbg <= 1'b1;
        run_is(1'b1);
        wr(ADDR_CTL3, 16'h0001);
        run_is(1'b0);
        dbg <= 1'b0;
        wr(ADDR_CTL2, 16'h0000);
        run_is(1'b0);
        wr(ADDR_CTL3, 16'h0002);
        rd(ADDR_CTL3, 16'h0002);
        $display("mode test done");
    endtask
    task automatic t_stop;
        wr(ADDR_CTL2, 16'h0080);
        wr(ADDR_CTL5, 16'h0020);
        repeat (2) @(posedge clk_i);
        run_is(1'b1);
        stop <= 1'b1;
        @(posedge clk_i);
        run_is(1'b0);
        stop <= 1'b0;
        wr(ADDR_CTL5, 16'h0020);
        n = 2;
        while (!req.run && n < 120) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk({15'h0, n >= T_SR_CYC && n <= T_SR_CYC + 6}, 16'h0001);
        $display("stop test done");
    endtask
    task automatic t_test;
        wr(ADDR_TEST, 16'h0019);
        @(posedge clk_i);
        #1 chk({12'h0, tsel}, 16'h0000);
        spec <= 1'b1;
        wr(ADDR_TEST, {10'h2A5, 6'h19});
        repeat (2) @(posedge clk_i);
        #1 chk({11'h0, ten, tsel}, 16'h0019);
        rd(ADDR_TEST, {10'h2A5, 6'h19});
        wr(ADDR_CTL2, 16'h00C0);
        wr(ADDR_TEST, 16'h0020);
        rd(ADDR_CTL2, 16'h0080);
        chk({12'h0, tsel}, 16'h0000);
        spec <= 1'b0;
        $display("test register test done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence with reset held for 16 cycles.
    initial begin
        {rst_n_i, wr_i, rd_i, spec, stop, wt, dbg} = '0;
        addr_i = '0;
        wdata_i = '0;
        pad = 8'h00;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_basic;
        t_single;
        t_fast;
        t_modes;
        t_stop;
        t_test;
        wrap_up;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        wrap_up;
    end
endmodule
